// ===== src/line_ctl_pkg.sv
/*
 * Shared constants and types of the serial line control channel:
 * register offsets, field positions, reset values and oversampling counts.
 * Assumes a 32-bit classic Wishbone slave with byte addresses.
 */
package line_ctl_pkg;

	// ----------------------------------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [5:0] OFS_DATA = 6'h00;
	localparam logic [5:0] OFS_INT_ENABLE = 6'h04;
	localparam logic [5:0] OFS_LINE_CONTROL = 6'h08;
	localparam logic [5:0] OFS_MODEM_CONTROL = 6'h0C;
	localparam logic [5:0] OFS_LINE_STATUS = 6'h10;
	localparam logic [5:0] OFS_RS485_CONTROL = 6'h14;
	localparam logic [5:0] OFS_ENHANCED_FEATURE = 6'h18;
	localparam logic [5:0] OFS_SECOND_PAUSE_CHAR = 6'h1C;
	localparam logic [5:0] OFS_EXTRA_FEATURE = 6'h20;
	localparam logic [5:0] OFS_DIVISOR = 6'h24;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int MULTIDROP_BIT = 0;
	localparam int RX_ENABLE_BIT = 1;
	localparam int AUTO_DIR_BIT = 4;
	localparam int RTS_INVERT_BIT = 5;
	localparam int SPECIAL_CHAR_BIT = 5;
	localparam int HW_RTS_FLOW_BIT = 6;
	localparam int IR_ENABLE_BIT = 1;
	localparam int IR11_SELECT_BIT = 4;
	localparam int LINE_STATUS_INT_BIT = 2;
	localparam int MANUAL_RTS_BIT = 1;
	localparam int PARITY_ENABLE_BIT = 3;
	localparam int EVEN_PARITY_BIT = 4;
	localparam int FORCED_PARITY_BIT = 5;
	localparam int DATA_READY_BIT = 0;
	localparam int PARITY_ERROR_BIT = 2;
	localparam int TX_FIFO_EMPTY_BIT = 5;
	localparam int TX_IDLE_BIT = 6;

	// ----------------------------------------------------------------
	// Reset values and timing counts
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_REG8 = 8'h00;
	localparam logic [15:0] RST_DIVISOR = 16'h0001;
	localparam logic [3:0] TICK_LAST = 4'hF;
	localparam logic [3:0] TICK_MID = 4'h7;
	localparam logic [3:0] IR10_PULSE_TICKS = 4'h3;
	localparam logic [3:0] IR11_PULSE_TICKS = 4'h4;
	localparam logic [4:0] IR_HOLD_TICKS = 5'h10;
	localparam int FIFO_DEPTH = 16;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic perr;
		logic [7:0] data;
	} rx_char_type;

	typedef enum logic [2:0] {
		SER_IDLE = 3'b000,
		SER_START = 3'b001,
		SER_DATA = 3'b010,
		SER_NINTH = 3'b011,
		SER_STOP = 3'b100
	} ser_state_type;

endpackage : line_ctl_pkg

// ===== src/stream_fifo.sv
/*
 * Synchronous FIFO with valid/ready on both sides.
 * Assumes one clock; the clock enable freezes it entirely.
 */
`timescale 1ns/1ps
module stream_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic clk, // Clock
	input wire logic rst, // Async reset, active high
	input wire logic ce, // Clock enable
	input wire logic [WIDTH-1:0] inDat, // Write data
	input wire logic inValid, // Write request
	output logic inReady, // Room available
	output logic [WIDTH-1:0] outDat, // Head data
	output logic outValid, // Head present
	input wire logic outReady // Head consumed
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wrPtr_q;
	logic [AW-1:0] rdPtr_q;
	logic [AW:0] count_q;
	wire logic push;
	wire logic pop;

	assign inReady = (count_q != (AW+1)'(DEPTH));
	assign outValid = (count_q != '0);
	assign push = inValid && inReady;
	assign pop = outValid && outReady;
	assign outDat = mem[rdPtr_q];

	always_ff @(posedge clk) begin
		if (ce && push) begin
			mem[wrPtr_q] <= inDat;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
			count_q <= '0;
		end else if (ce) begin
			if (push) wrPtr_q <= wrPtr_q + 1'b1;
			if (pop) rdPtr_q <= rdPtr_q + 1'b1;
			if (push && !pop) count_q <= count_q + 1'b1;
			else if (pop && !push) count_q <= count_q - 1'b1;
		end
	end

endmodule : stream_fifo

// ===== src/line_ctl.sv
/*
 * One serial channel with RS-485 direction control, 9-bit multidrop
 * reception with address screening, and an IrDA pulse encoder/decoder.
 * Assumes a classic Wishbone master and an external line transceiver.
 */
`timescale 1ns/1ps
// Overview of operation
// - Auto direction bit overrides manual and flow RTS
// - Host write raises RTS; last bit lowers
// - Inversion bit flips auto direction RTS polarity
// - Multidrop bit selects nine-bit reception, ninth marks address
// - Disabled receiver drops data but keeps addresses
// - Address sets parity error under forced even parity, stored, raises interrupt
// - Enabled receiver keeps all; addresses flag parity error under forced even parity
// - Auto detection drops data while disabled, and mismatched addresses
// - Matching address enables receiver, stored, interrupt raised
// - Mismatched address disables receiver; match stored flagged
// - Infrared enable: three-sixteenths pulse per zero bit
// - Second select: quarter-bit pulse per zero bit
// - Infrared transmit and receive idle low
// - Each detected light pulse gives decoder data
// - Interrupt enable bit two gates line status interrupt
module line_ctl
	import line_ctl_pkg::*;
(
	input wire logic clk, // Clock, 50 MHz
	input wire logic rst, // Async reset, active high
	input wire logic ce, // Clock enable
	input wire logic [5:0] adr_i, // Wishbone byte address
	input wire logic [31:0] dat_i, // Wishbone write data
	output logic [31:0] dat_o, // Wishbone read data
	input wire logic we_i, // Wishbone write enable
	input wire logic [3:0] sel_i, // Wishbone byte selects
	input wire logic cyc_i, // Wishbone cycle
	input wire logic stb_i, // Wishbone strobe
	output logic ack_o, // Wishbone acknowledge
	input wire logic rxPin, // Serial input pin
	output logic txPin, // Serial output pin
	output logic rtsN, // Request-to-send, active low
	output logic lineStatusIrq, // Line status interrupt
	output logic txRoom // Transmit FIFO can take a byte
);
	// ----------------------------------------------------------------
	// Register bus
	// ----------------------------------------------------------------
	logic ack_q;
	logic [31:0] rdData_q;
	logic [7:0] intEnable_q;
	logic [7:0] lineControl_q;
	logic [7:0] modemControl_q;
	logic [7:0] rs485Control_q;
	logic [7:0] enhancedFeature_q;
	logic [7:0] secondPauseChar_q;
	logic [7:0] extraFeature_q;
	logic [15:0] divisor_q;
	logic [31:0] rdMux;

	wire logic wbReq = cyc_i && stb_i;
	wire logic wbTake = wbReq && !ack_q;
	wire logic wbWrite = wbReq && ack_q && we_i;
	wire logic wbRead = wbReq && ack_q && !we_i;
	wire logic wrLow = wbWrite && sel_i[0];
	wire logic dataWrite = wrLow && adr_i == OFS_DATA;
	wire logic dataRead = wbRead && adr_i == OFS_DATA;
	wire logic statusRead = wbRead && adr_i == OFS_LINE_STATUS;

	assign ack_o = ack_q;
	assign dat_o = rdData_q;

	wire logic multidrop = rs485Control_q[MULTIDROP_BIT];
	wire logic rxEnable = rs485Control_q[RX_ENABLE_BIT];
	wire logic autoDir = rs485Control_q[AUTO_DIR_BIT];
	wire logic rtsInvert = rs485Control_q[RTS_INVERT_BIT];
	wire logic autoAddr = multidrop && enhancedFeature_q[SPECIAL_CHAR_BIT];
	wire logic hwRtsFlow = enhancedFeature_q[HW_RTS_FLOW_BIT];
	wire logic irEnable = extraFeature_q[IR_ENABLE_BIT];
	wire logic ir11 = extraFeature_q[IR11_SELECT_BIT];
	wire logic ninthOn = multidrop || lineControl_q[PARITY_ENABLE_BIT];

	// ----------------------------------------------------------------
	// FIFOs
	// ----------------------------------------------------------------
	logic [7:0] txHead;
	logic txValid;
	logic txPop;
	rx_char_type rxIn;
	rx_char_type rxHead;
	logic rxPush;
	logic rxInReady;
	logic rxValid;

	stream_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) txFifo (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.inDat(dat_i[7:0]),
		.inValid(dataWrite),
		.inReady(txRoom),
		.outDat(txHead),
		.outValid(txValid),
		.outReady(txPop)
	);

	stream_fifo #(.WIDTH($bits(rx_char_type)), .DEPTH(FIFO_DEPTH)) rxFifo (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.inDat(rxIn),
		.inValid(rxPush),
		.inReady(rxInReady),
		.outDat(rxHead),
		.outValid(rxValid),
		.outReady(dataRead)
	);

	// ----------------------------------------------------------------
	// Baud tick, sixteen per bit
	// ----------------------------------------------------------------
	logic [15:0] divCnt_q;
	wire logic tick = (divisor_q != '0) && (divCnt_q == divisor_q - 16'h0001);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) divCnt_q <= '0;
		else if (ce) divCnt_q <= tick ? '0 : divCnt_q + 16'h0001;
	end

	// ----------------------------------------------------------------
	// Transmitter
	// ----------------------------------------------------------------
	ser_state_type txState_q;
	logic [3:0] txTick_q;
	logic [2:0] txIdx_q;
	logic [7:0] txShift_q;
	logic txNinth_q;
	logic txBit;
	logic txDir_q;

	wire logic txBitEnd = tick && txTick_q == TICK_LAST;
	wire logic txDone = txState_q == SER_STOP && txBitEnd;
	wire logic txStart = txState_q == SER_IDLE && tick && txValid;
	wire logic txParity = lineControl_q[FORCED_PARITY_BIT] ? !lineControl_q[EVEN_PARITY_BIT]
		: (^txHead) ^ !lineControl_q[EVEN_PARITY_BIT];
	wire logic [3:0] irWidth = ir11 ? IR11_PULSE_TICKS : IR10_PULSE_TICKS;

	assign txPop = txStart;

	always_comb begin
		unique case (txState_q)
			SER_START: txBit = 1'b0;
			SER_DATA: txBit = txShift_q[0];
			SER_NINTH: txBit = txNinth_q;
			default: txBit = 1'b1;
		endcase
	end

	// Pulse only within the first part of a zero bit; idles low
	assign txPin = irEnable ? (txState_q != SER_IDLE && !txBit && txTick_q < irWidth) : txBit;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			txState_q <= SER_IDLE;
			txTick_q <= '0;
			txIdx_q <= '0;
			txShift_q <= '0;
			txNinth_q <= 1'b0;
		end else if (ce) begin
			if (tick) txTick_q <= txTick_q + 4'h1;
			if (txStart) begin
				txState_q <= SER_START;
				txTick_q <= '0;
				txShift_q <= txHead;
				txNinth_q <= txParity;
			end else if (txBitEnd) begin
				unique case (txState_q)
					SER_START: txState_q <= SER_DATA;
					SER_DATA: begin
						txShift_q <= {1'b0, txShift_q[7:1]};
						txIdx_q <= txIdx_q + 3'h1;
						if (txIdx_q == 3'h7) txState_q <= ninthOn ? SER_NINTH : SER_STOP;
					end
					SER_NINTH: txState_q <= SER_STOP;
					SER_STOP: txState_q <= SER_IDLE;
					SER_IDLE: txState_q <= SER_IDLE;
					default: txState_q <= SER_IDLE;
				endcase
			end
		end
	end

	// High from the host's write until the last bit leaves with nothing queued
	always_ff @(posedge clk or posedge rst) begin
		if (rst) txDir_q <= 1'b0;
		else if (ce) begin
			if (dataWrite && txRoom) txDir_q <= 1'b1;
			else if (txDone && !txValid) txDir_q <= 1'b0;
		end
	end

	// Auto direction overrides flow control RTS, which overrides manual RTS
	assign rtsN = autoDir ? (txDir_q ^ rtsInvert)
		: hwRtsFlow ? !rxInReady : !modemControl_q[MANUAL_RTS_BIT];

	// ----------------------------------------------------------------
	// Receive input: three-stage synchroniser, IrDA decoder
	// ----------------------------------------------------------------
	logic [2:0] rxSync_q;
	logic rxFilt_q;
	logic rxFiltPrev_q;
	logic [4:0] irHold_q;

	// A detected pulse marks one bit time on the decoded stream
	wire logic irPulse = rxFilt_q && !rxFiltPrev_q;
	wire logic rxLine = irEnable ? (irHold_q == '0) : rxFilt_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rxSync_q <= 3'h7;
			rxFilt_q <= 1'b1;
			rxFiltPrev_q <= 1'b1;
			irHold_q <= '0;
		end else if (ce) begin
			rxSync_q <= {rxSync_q[1:0], rxPin};
			if (rxSync_q[1] == rxSync_q[2]) rxFilt_q <= rxSync_q[2];
			rxFiltPrev_q <= rxFilt_q;
			if (irPulse) irHold_q <= IR_HOLD_TICKS;
			else if (tick && irHold_q != '0) irHold_q <= irHold_q - 5'h01;
		end
	end

	// ----------------------------------------------------------------
	// Receiver
	// ----------------------------------------------------------------
	ser_state_type rxState_q;
	logic [3:0] rxTick_q;
	logic [2:0] rxIdx_q;
	logic [7:0] rxShift_q;
	logic rxNinth_q;
	logic perrFlag_q;

	wire logic rxSample = tick && (rxState_q == SER_START ? rxTick_q == TICK_MID : rxTick_q == TICK_LAST);
	wire logic charDone = rxState_q == SER_STOP && rxSample;
	wire logic [7:0] rxData = rxShift_q;
	wire logic expParity = lineControl_q[FORCED_PARITY_BIT] ? !lineControl_q[EVEN_PARITY_BIT]
		: (^rxData) ^ !lineControl_q[EVEN_PARITY_BIT];
	wire logic isAddr = multidrop && rxNinth_q;
	wire logic addrMatch = rxData == secondPauseChar_q;
	wire logic autoSet = charDone && autoAddr && isAddr && addrMatch;
	wire logic autoClr = charDone && autoAddr && isAddr && !addrMatch;
	// Multidrop keeps data only when enabled; addresses kept unless auto detection sees a mismatch
	wire logic keepChar = !multidrop ? 1'b1 : autoAddr ? (isAddr ? addrMatch : rxEnable) : (rxEnable || isAddr);

	assign rxPush = charDone && keepChar;
	assign rxIn.data = rxData;
	// Auto detection reports the ninth bit itself as the parity error
	assign rxIn.perr = autoAddr ? rxNinth_q : (ninthOn && rxNinth_q != expParity);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rxState_q <= SER_IDLE;
			rxTick_q <= '0;
			rxIdx_q <= '0;
			rxShift_q <= '0;
			rxNinth_q <= 1'b0;
		end else if (ce) begin
			if (tick) rxTick_q <= rxSample ? 4'h0 : rxTick_q + 4'h1;
			if (rxState_q == SER_IDLE && tick && !rxLine) begin
				rxState_q <= SER_START;
				rxTick_q <= '0;
			end else if (rxSample) begin
				unique case (rxState_q)
					SER_START: rxState_q <= rxLine ? SER_IDLE : SER_DATA;
					SER_DATA: begin
						rxShift_q <= {rxLine, rxShift_q[7:1]};
						rxIdx_q <= rxIdx_q + 3'h1;
						rxNinth_q <= 1'b0;
						if (rxIdx_q == 3'h7) rxState_q <= ninthOn ? SER_NINTH : SER_STOP;
					end
					SER_NINTH: begin
						rxNinth_q <= rxLine;
						rxState_q <= SER_STOP;
					end
					SER_STOP: rxState_q <= SER_IDLE;
					SER_IDLE: rxState_q <= SER_IDLE;
					default: rxState_q <= SER_IDLE;
				endcase
			end
		end
	end

	// Sticky parity error for the interrupt; a new error wins over the status read
	always_ff @(posedge clk or posedge rst) begin
		if (rst) perrFlag_q <= 1'b0;
		else if (ce) begin
			if (rxPush && rxInReady && rxIn.perr) perrFlag_q <= 1'b1;
			else if (statusRead) perrFlag_q <= 1'b0;
		end
	end

	assign lineStatusIrq = intEnable_q[LINE_STATUS_INT_BIT] && perrFlag_q;

	// ----------------------------------------------------------------
	// Register file
	// ----------------------------------------------------------------
	wire logic [7:0] lineStatus = {1'b0, txState_q == SER_IDLE && !txValid, !txValid, 2'b00,
		rxValid && rxHead.perr, 1'b0, rxValid};

	always_comb begin
		unique case (adr_i)
			OFS_DATA: rdMux = {24'h000000, rxHead.data};
			OFS_INT_ENABLE: rdMux = {24'h000000, intEnable_q};
			OFS_LINE_CONTROL: rdMux = {24'h000000, lineControl_q};
			OFS_MODEM_CONTROL: rdMux = {24'h000000, modemControl_q};
			OFS_LINE_STATUS: rdMux = {24'h000000, lineStatus};
			OFS_RS485_CONTROL: rdMux = {24'h000000, rs485Control_q};
			OFS_ENHANCED_FEATURE: rdMux = {24'h000000, enhancedFeature_q};
			OFS_SECOND_PAUSE_CHAR: rdMux = {24'h000000, secondPauseChar_q};
			OFS_EXTRA_FEATURE: rdMux = {24'h000000, extraFeature_q};
			OFS_DIVISOR: rdMux = {16'h0000, divisor_q};
			default: rdMux = 32'h00000000;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ack_q <= 1'b0;
			rdData_q <= '0;
		end else if (ce) begin
			ack_q <= wbTake;
			if (wbTake) rdData_q <= rdMux;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			intEnable_q <= RST_REG8;
			lineControl_q <= RST_REG8;
			modemControl_q <= RST_REG8;
			enhancedFeature_q <= RST_REG8;
			secondPauseChar_q <= RST_REG8;
			extraFeature_q <= RST_REG8;
			divisor_q <= RST_DIVISOR;
		end else if (ce) begin
			if (wrLow && adr_i == OFS_INT_ENABLE) intEnable_q <= dat_i[7:0];
			if (wrLow && adr_i == OFS_LINE_CONTROL) lineControl_q <= dat_i[7:0];
			if (wrLow && adr_i == OFS_MODEM_CONTROL) modemControl_q <= dat_i[7:0];
			if (wrLow && adr_i == OFS_ENHANCED_FEATURE) enhancedFeature_q <= dat_i[7:0];
			if (wrLow && adr_i == OFS_SECOND_PAUSE_CHAR) secondPauseChar_q <= dat_i[7:0];
			if (wrLow && adr_i == OFS_EXTRA_FEATURE) extraFeature_q <= dat_i[7:0];
			if (wrLow && adr_i == OFS_DIVISOR) divisor_q[7:0] <= dat_i[7:0];
			if (wbWrite && sel_i[1] && adr_i == OFS_DIVISOR) divisor_q[15:8] <= dat_i[15:8];
		end
	end

	// Address screening in auto detection overrides a same-cycle software write
	always_ff @(posedge clk or posedge rst) begin
		if (rst) rs485Control_q <= RST_REG8;
		else if (ce) begin
			if (wrLow && adr_i == OFS_RS485_CONTROL) rs485Control_q <= dat_i[7:0];
			if (autoSet) rs485Control_q[RX_ENABLE_BIT] <= 1'b1;
			else if (autoClr) rs485Control_q[RX_ENABLE_BIT] <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence sHostWrite;
		ce && autoDir && dataWrite && txRoom;
	endsequence

	sequence sMatchAddr;
		ce && charDone && autoAddr && isAddr && addrMatch;
	endsequence

	a_rts_write_high: assert property (sHostWrite ##0 !rtsInvert |=> rtsN)
		else $error("RTS not released after host write");
	a_rts_inverted: assert property (sHostWrite ##0 rtsInvert |=> !rtsN)
		else $error("Inverted RTS did not follow host write");
	a_rts_last_bit: assert property (ce && autoDir && !rtsInvert && txDone && !txValid && !wbWrite |=> !rtsN)
		else $error("RTS not asserted after last bit");
	a_rts_manual_mode: assert property (!autoDir && !hwRtsFlow |-> rtsN == !modemControl_q[MANUAL_RTS_BIT])
		else $error("Manual RTS not honoured");
	a_md_drop_data: assert property (charDone && multidrop && !autoAddr && !rxEnable && !rxNinth_q |-> !rxPush)
		else $error("Data kept while receiver disabled");
	a_md_addr_store: assert property (charDone && multidrop && !autoAddr && isAddr
		&& lineControl_q[EVEN_PARITY_BIT] && lineControl_q[FORCED_PARITY_BIT] |-> rxPush && rxIn.perr)
		else $error("Address not stored with parity error");
	a_auto_match: assert property (sMatchAddr |-> rxPush && rxIn.perr ##1 rxEnable)
		else $error("Matching address not accepted");
	a_auto_mismatch: assert property (ce && charDone && autoAddr && isAddr && !addrMatch |-> !rxPush ##1 !rxEnable)
		else $error("Mismatched address not dropped");
	a_auto_drop_data: assert property (charDone && autoAddr && !rxEnable && !isAddr |-> !rxPush)
		else $error("Data kept in auto detection while disabled");
	a_ir_idle_low: assert property (irEnable && txState_q == SER_IDLE |-> !txPin)
		else $error("Infrared output not idle low");
	a_ir_pulse_width: assert property (irEnable && txPin |-> !txBit
		&& txTick_q < (ir11 ? IR11_PULSE_TICKS : IR10_PULSE_TICKS))
		else $error("Infrared pulse outside its width");
	a_irq_on_perr: assert property (ce && rxPush && rxInReady && rxIn.perr && intEnable_q[LINE_STATUS_INT_BIT]
		&& !wbWrite |=> lineStatusIrq)
		else $error("Line status interrupt missing");

endmodule : line_ctl

// ===== dv/line_partner.sv
/*
 * Remote station model: sends frames of 8 or 9 bits as UART levels or IrDA pulses.
 * Assumes divisor 1, so one bit time is 16 clocks.
 */
`timescale 1ns/1ps
module line_partner (
	input wire logic clk, // Clock
	input wire logic irMode, // Send IrDA pulses
	output logic rxPin // Line into the block
);
	logic busy = 1'b0;

	initial rxPin = 1'b1;

	// ----------------------------------------------------------------
	// Idle level: high for UART, dark for IrDA
	// ----------------------------------------------------------------
	always @(posedge clk) begin
		if (!busy) rxPin <= !irMode;
	end

	// ----------------------------------------------------------------
	// Frame sender
	// ----------------------------------------------------------------
	task automatic sendChar(input logic [8:0] ch, input logic nine);
		logic [10:0] f;
		int n;
		f = {1'b1, ch, 1'b0};
		n = nine ? 11 : 10;
		if (!nine) f[9] = 1'b1;
		busy = 1'b1;
		for (int i = 0; i < n; i++) begin
			for (int t = 0; t < 16; t++) begin
				@(posedge clk);
				rxPin <= irMode ? (!f[i] && t < 3) : f[i];
			end
		end
		busy = 1'b0;
	endtask : sendChar
endmodule : line_partner

// ===== dv/tb_top.sv
/*
 * Testbench of the line control channel: registers, RS-485 direction,
 * multidrop screening, IrDA and the receive FIFO.
 * Assumes divisor 1 after reset and the remote station model.
 */
`timescale 1ns/1ps
module tb_top
	import line_ctl_pkg::*;
;
	logic clk, rst, we, cyc, stb, ack, irMode, rxPin, txPin, rtsN, irq, txRoom;
	logic [5:0] adr;
	logic [3:0] sel;
	logic [31:0] datI, datO;
	logic [7:0] q;
	int mismatches = 0;
	int comparisons = 0;

	line_ctl dut (.clk(clk), .rst(rst), .ce(1'b1), .adr_i(adr), .dat_i(datI), .dat_o(datO), .we_i(we),
		.sel_i(sel), .cyc_i(cyc), .stb_i(stb), .ack_o(ack), .rxPin(rxPin), .txPin(txPin), .rtsN(rtsN),
		.lineStatusIrq(irq), .txRoom(txRoom));
	line_partner p (.clk(clk), .irMode(irMode), .rxPin(rxPin));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic stop_test();
		$display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
		if (mismatches == 0 && comparisons > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : stop_test

	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic wb(input logic [5:0] a, input logic w, input logic [7:0] d);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		datI <= {24'h000000, d};
		@(posedge clk);
		while (ack !== 1'b1 && n < 50) begin
			@(posedge clk);
			n++;
		end
		q = datO[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
		if (n == 50) mismatches++;
	endtask : wb

	task automatic rdChk(input logic [5:0] a, input logic [7:0] exp, input string nm);
		wb(a, 1'b0, 8'h00);
		chk(nm, q, exp);
	endtask : rdChk

	task automatic rx(input logic [8:0] ch, input logic nine, input logic ie, input logic [7:0] line_status_reg);
		p.sendChar(ch, nine);
		repeat (4) @(posedge clk);
		chk("irq", 8'(irq), 8'(ie));
		rdChk(OFS_LINE_STATUS, line_status_reg, "status");
		chk("irq clear", 8'(irq), 8'h00);
		if (line_status_reg[0]) rdChk(OFS_DATA, ch[7:0], "data");
	endtask : rx

	task automatic doReset();
		rst <= 1'b1;
		irMode <= 1'b0;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
	endtask : doReset

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic tReset();
		doReset();
		chk("pins", 8'({rtsN, txPin, irq, txRoom}), 8'h0D);
		rdChk(OFS_LINE_STATUS, 8'h60, "status");
		rdChk(OFS_DIVISOR, 8'h01, "divisor");
		rdChk(OFS_INT_ENABLE, 8'h00, "int enable");
		rdChk(6'h3C, 8'h00, "unmapped");
	endtask : tReset

	task automatic tAutoDir(input logic inv);
		logic [7:0] d;
		int n;
		doReset();
		wb(OFS_MODEM_CONTROL, 1'b1, inv ? 8'h02 : 8'h00);
		wb(OFS_RS485_CONTROL, 1'b1, inv ? 8'h30 : 8'h10);
		chk("rts idle", 8'(rtsN), 8'(inv));
		wb(OFS_DATA, 1'b1, 8'hA5);
		chk("rts busy", 8'(rtsN), 8'(!inv));
		n = 0;
		while (txPin !== 1'b0 && n < 40) begin
			@(posedge clk);
			n++;
		end
		repeat (8) @(posedge clk);
		for (int i = 0; i < 8; i++) begin
			repeat (16) @(posedge clk);
			d[i] = txPin;
		end
		chk("tx data", d, 8'hA5);
		chk("rts last bit", 8'(rtsN), 8'(!inv));
		n = 0;
		while (rtsN !== inv && n < 40) begin
			@(posedge clk);
			n++;
		end
		chk("rts done", 8'(rtsN), 8'(inv));
		chk("rts hold", 8'(n > 20), 8'h01);
	endtask : tAutoDir

	task automatic tMulti();
		doReset();
		wb(OFS_INT_ENABLE, 1'b1, 8'h04);
		wb(OFS_LINE_CONTROL, 1'b1, 8'h38);
		wb(OFS_RS485_CONTROL, 1'b1, 8'h01);
		rx(9'h011, 1'b1, 1'b0, 8'h60);
		rx(9'h142, 1'b1, 1'b1, 8'h65);
		wb(OFS_RS485_CONTROL, 1'b1, 8'h03);
		rx(9'h011, 1'b1, 1'b0, 8'h61);
		wb(OFS_INT_ENABLE, 1'b1, 8'h00);
		rx(9'h177, 1'b1, 1'b0, 8'h65);
		wb(OFS_RS485_CONTROL, 1'b1, 8'h00);
		wb(OFS_LINE_CONTROL, 1'b1, 8'h18);
		rx(9'h103, 1'b1, 1'b0, 8'h65);
		rx(9'h107, 1'b1, 1'b0, 8'h61);
	endtask : tMulti

	task automatic tAutoAddr();
		doReset();
		wb(OFS_INT_ENABLE, 1'b1, 8'h04);
		wb(OFS_LINE_CONTROL, 1'b1, 8'h38);
		wb(OFS_ENHANCED_FEATURE, 1'b1, 8'h20);
		wb(OFS_SECOND_PAUSE_CHAR, 1'b1, 8'h5A);
		wb(OFS_RS485_CONTROL, 1'b1, 8'h01);
		rx(9'h05A, 1'b1, 1'b0, 8'h60);
		rx(9'h15B, 1'b1, 1'b0, 8'h60);
		rx(9'h1DA, 1'b1, 1'b0, 8'h60);
		rx(9'h15A, 1'b1, 1'b1, 8'h65);
		rdChk(OFS_RS485_CONTROL, 8'h03, "rx enable");
		rx(9'h033, 1'b1, 1'b0, 8'h61);
		rx(9'h15A, 1'b1, 1'b1, 8'h65);
		rx(9'h1DA, 1'b1, 1'b0, 8'h60);
		rdChk(OFS_RS485_CONTROL, 8'h01, "rx disable");
		rx(9'h033, 1'b1, 1'b0, 8'h60);
	endtask : tAutoAddr

	task automatic tIrda(input logic v11);
		int n;
		doReset();
		wb(OFS_EXTRA_FEATURE, 1'b1, v11 ? 8'h12 : 8'h02);
		irMode <= 1'b1;
		chk("ir idle", 8'(txPin), 8'h00);
		wb(OFS_DATA, 1'b1, 8'hFE);
		n = 0;
		while (txPin !== 1'b1 && n < 40) begin
			@(posedge clk);
			n++;
		end
		n = 0;
		while (txPin === 1'b1 && n < 20) begin
			@(posedge clk);
			n++;
		end
		chk("ir pulse", 8'(n), v11 ? 8'h04 : 8'h03);
		repeat (200) @(posedge clk);
		rx(9'h03C, 1'b0, 1'b0, 8'h61);
	endtask : tIrda

	task automatic tFill();
		doReset();
		wb(OFS_MODEM_CONTROL, 1'b1, 8'h02);
		wb(OFS_ENHANCED_FEATURE, 1'b1, 8'h40);
		chk("rts flow open", 8'(rtsN), 8'h00);
		for (int i = 0; i < 17; i++) p.sendChar(9'(i), 1'b0);
		repeat (4) @(posedge clk);
		chk("rts flow full", 8'(rtsN), 8'h01);
		wb(OFS_RS485_CONTROL, 1'b1, 8'h10);
		chk("rts override", 8'(rtsN), 8'h00);
		for (int i = 0; i < FIFO_DEPTH; i++) rdChk(OFS_DATA, 8'(i), "fifo data");
		rdChk(OFS_LINE_STATUS, 8'h60, "fifo empty");
	endtask : tFill

	initial begin
		rst = 1'b1;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 6'h00;
		datI = 32'h00000000;
		sel = 4'hF;
		irMode = 1'b0;
		tReset();
		tAutoDir(1'b0);
		tAutoDir(1'b1);
		tMulti();
		tAutoAddr();
		tIrda(1'b0);
		tIrda(1'b1);
		tFill();
		stop_test();
	end

	initial begin
		repeat (30000) @(posedge clk);
		mismatches++;
		stop_test();
	end
endmodule : tb_top
